// *** rtl/cda_alu_regs.vh ***
// Constants for the compare and divide step execution slice
`ifndef CDA_ALU_REGS_VH
`define CDA_ALU_REGS_VH
`define CDA_OP_NONE       4'h0
`define CDA_OP_FLAG_CLEAR 4'h1
`define CDA_OP_EQ         4'h2
`define CDA_OP_GE         4'h3
`define CDA_OP_GT         4'h4
`define CDA_OP_HI         4'h5
`define CDA_OP_HS         4'h6
`define CDA_OP_PL         4'h7
`define CDA_OP_PZ         4'h8
`define CDA_OP_STR        4'h9
`define CDA_OP_EQIMM      4'hA
`define CDA_OP_SDIV_INIT  4'hB
`define CDA_OP_UDIV_INIT  4'hC
`define CDA_OP_DIV_STEP   4'hD
`define CDA_PC_STEP       32'h0000_0002
`define CDA_PC_RESET      32'h0000_0000
`define CDA_WORD_RESET    32'h0000_0000
`define CDA_WORD_ZERO     32'h0000_0000
`define CDA_BYTE_ZERO     8'h00
`define CDA_BIT_CLEAR     1'h0
`define CDA_BIT_SET       1'h1
`define CDA_MSB           31
`define CDA_WORD_W        32
`define CDA_IMM_MSB       7
`define CDA_EXT_W         24
`define CDA_LANE3_HI      31
`define CDA_LANE3_LO      24
`define CDA_LANE2_HI      23
`define CDA_LANE2_LO      16
`define CDA_LANE1_HI      15
`define CDA_LANE1_LO      8
`define CDA_LANE0_HI      7
`define CDA_LANE0_LO      0
`endif

// *** rtl/cda_alu.v ***
// Compare, flag-clear and divide-step execution slice
// Behaviour
// (RULE1) Flag-clear op forces condition flag to zero and advances PC by two.
// (RULE2) Every compare writes flag one if condition holds, else zero, in one cycle.
// (RULE3) Compares never write any general register; only the flag changes.
// (RULE4) Equal compare sets flag when both operands match on all 32 bits.
// (RULE5) Signed greater-or-equal compare uses two's-complement operands.
// (RULE6) Signed greater-than compare sets flag only on strict signed excess.
// (RULE7) Unsigned greater-than compare sets flag only on strict unsigned excess.
// (RULE8) Unsigned greater-or-equal compare sets flag when dest is not below source.
// (RULE9) Positive compare tests dest above zero; nonnegative tests dest at or above zero.
// (RULE10) Byte-match compare sets flag when any byte of the XOR is zero.
// (RULE11) Immediate compare sign-extends 8-bit immediate and tests register zero.
// (RULE12) Signed divide init copies MSBs to sign bits, flag gets their XOR.
// (RULE13) Unsigned divide init clears both sign bits and the flag.
// (RULE14) Divide step shifts dividend left, adds or subtracts divisor, records quotient bit.
// (RULE15) Divide step has no zero-divisor, overflow or remainder handling.
// (RULE16) Program must not touch divide operands or status bits mid-sequence.
// (RULE17) Program rotates the quotient register through the flag for wide quotients.
// (RULE18) Step shifts old flag in, subtracts on equal signs, flag is sign equality.
// (RULE19) Every operation advances PC by two and writes only its own registers.
`include "cda_alu_regs.vh"
module cda_alu
(
    input  wire        clk,
    input  wire        rstn,
    input  wire        op_valid,
    input  wire [3:0]  op_code,
    input  wire [31:0] dest_operand_reg,
    input  wire [31:0] source_operand_reg,
    input  wire [31:0] reg_zero,
    input  wire [7:0]  imm,
    output reg         flag_t,
    output reg         dividend_sign,
    output reg         divisor_sign,
    output reg  [31:0] pc,
    output reg         wr_en,
    output reg  [31:0] wr_data
);

    reg        next_t;
    reg        next_q;
    reg        next_m;
    reg        next_wr;
    reg [31:0] next_data;
    reg [31:0] next_pc;
    reg [31:0] xr;
    reg [31:0] shifted;
    reg [32:0] sum;
    reg        carry;
    reg        shq;
    reg        subtract;

    // Signed compare via sign-bit flip keeps one comparator style for both
    function ge_signed;
        input [31:0] a;
        input [31:0] b;
        begin
            ge_signed = {~a[`CDA_MSB], a[`CDA_MSB-1:0]} >= {~b[`CDA_MSB], b[`CDA_MSB-1:0]};
        end
    endfunction

    // True when at least one of the four byte lanes is all zero
    function lane_zero;
        input [31:0] w;
        begin
            lane_zero = (w[`CDA_LANE3_HI:`CDA_LANE3_LO] == `CDA_BYTE_ZERO)
                     || (w[`CDA_LANE2_HI:`CDA_LANE2_LO] == `CDA_BYTE_ZERO)
                     || (w[`CDA_LANE1_HI:`CDA_LANE1_LO] == `CDA_BYTE_ZERO)
                     || (w[`CDA_LANE0_HI:`CDA_LANE0_LO] == `CDA_BYTE_ZERO);
        end
    endfunction

    // Immediate widened with its own sign so negative literals still match
    function [31:0] sext_imm;
        input [7:0] i;
        begin
            sext_imm = {{`CDA_EXT_W{i[`CDA_IMM_MSB]}}, i};
        end
    endfunction

    // One adder serves both step directions; the top bit is carry or borrow
    function [32:0] step_sum;
        input [31:0] a;
        input [31:0] b;
        input        sub;
        begin
            if (sub)
                step_sum = {`CDA_BIT_CLEAR, a} - {`CDA_BIT_CLEAR, b};
            else
                step_sum = {`CDA_BIT_CLEAR, a} + {`CDA_BIT_CLEAR, b};
        end
    endfunction

    // Unknown codes still occupy an instruction slot, so they move the pc too
    function op_taken;
        input       valid;
        input [3:0] code;
        begin
            op_taken = valid && (code != `CDA_OP_NONE);
        end
    endfunction

    always @*
    begin
        next_t    = flag_t;
        next_q    = dividend_sign;
        next_m    = divisor_sign;
        next_wr   = `CDA_BIT_CLEAR;
        next_data = wr_data;
        next_pc   = pc;
        xr        = dest_operand_reg ^ source_operand_reg;
        shifted   = {dest_operand_reg[`CDA_MSB-1:0], flag_t}; // RULE18
        shq       = dest_operand_reg[`CDA_MSB];
        subtract  = (dividend_sign == divisor_sign); // RULE18
        sum       = step_sum(shifted, source_operand_reg, subtract);
        carry     = sum[`CDA_WORD_W];
        if (op_taken(op_valid, op_code))
        begin
            next_pc = pc + `CDA_PC_STEP; // RULE19 RULE1
        end
        if (op_valid)
        begin
            case (op_code)
                `CDA_OP_FLAG_CLEAR:
                begin
                    next_t = `CDA_BIT_CLEAR; // RULE1
                end
                `CDA_OP_EQ:
                begin
                    next_t = (dest_operand_reg == source_operand_reg); // RULE4 RULE2
                end
                `CDA_OP_GE:
                begin
                    next_t = ge_signed(dest_operand_reg, source_operand_reg); // RULE5
                end
                `CDA_OP_GT:
                begin
                    next_t = ge_signed(dest_operand_reg, source_operand_reg)
                             && (xr != `CDA_WORD_ZERO); // RULE6
                end
                `CDA_OP_HI:
                begin
                    next_t = dest_operand_reg > source_operand_reg; // RULE7
                end
                `CDA_OP_HS:
                begin
                    next_t = dest_operand_reg >= source_operand_reg; // RULE8
                end
                `CDA_OP_PL:
                begin
                    next_t = ~dest_operand_reg[`CDA_MSB]
                             && (dest_operand_reg != `CDA_WORD_ZERO); // RULE9
                end
                `CDA_OP_PZ:
                begin
                    next_t = ~dest_operand_reg[`CDA_MSB]; // RULE9
                end
                `CDA_OP_STR:
                begin
                    next_t = lane_zero(xr); // RULE10
                end
                `CDA_OP_EQIMM:
                begin
                    next_t = (reg_zero == sext_imm(imm)); // RULE11 RULE3
                end
                `CDA_OP_SDIV_INIT:
                begin
                    next_q = dest_operand_reg[`CDA_MSB]; // RULE12
                    next_m = source_operand_reg[`CDA_MSB];
                    next_t = dest_operand_reg[`CDA_MSB] ^ source_operand_reg[`CDA_MSB];
                end
                `CDA_OP_UDIV_INIT:
                begin
                    next_q = `CDA_BIT_CLEAR; // RULE13
                    next_m = `CDA_BIT_CLEAR;
                    next_t = `CDA_BIT_CLEAR;
                end
                `CDA_OP_DIV_STEP:
                begin
                    // No divisor checks here: software screens zero and overflow first
                    next_q    = shq ^ carry ^ divisor_sign; // RULE14 RULE15
                    next_t    = (next_q == divisor_sign); // RULE18
                    next_wr   = `CDA_BIT_SET; // RULE19
                    next_data = sum[`CDA_MSB:0];
                end
                default:
                begin
                    next_t = flag_t;
                end
            endcase
        end
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            flag_t <= `CDA_BIT_CLEAR;
        end
        else
        begin
            flag_t <= next_t; // RULE2
        end
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            dividend_sign <= `CDA_BIT_CLEAR;
            divisor_sign  <= `CDA_BIT_CLEAR;
        end
        else
        begin
            dividend_sign <= next_q; // RULE12 RULE13 RULE14
            divisor_sign  <= next_m;
        end
    end

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pc <= `CDA_PC_RESET;
        end
        else
        begin
            pc <= next_pc; // RULE19
        end
    end

    // Strobe lasts one cycle; the data word holds so the caller may read it late
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wr_en   <= `CDA_BIT_CLEAR;
            wr_data <= `CDA_WORD_RESET;
        end
        else
        begin
            wr_en   <= next_wr; // RULE3
            wr_data <= next_data;
        end
    end

endmodule

// *** tb/cda_alu_asserts.sv ***
// Port-level checks on the compare and divide step slice
module cda_alu_asserts
(
    input wire        clk,
    input wire        rstn,
    input wire        op_valid,
    input wire [3:0]  op_code,
    input wire [31:0] dest_operand_reg,
    input wire [31:0] source_operand_reg,
    input wire        flag_t,
    input wire        dividend_sign,
    input wire        divisor_sign,
    input wire [31:0] pc,
    input wire        wr_en
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle cycles fold into code zero so no check fires on them
    wire [3:0] c  = op_valid ? op_code : 4'h0;
    wire       eq = dest_operand_reg == source_operand_reg;
    wire       hi = dest_operand_reg > source_operand_reg;
    wire       ms = source_operand_reg[31];
    wire       ds = dest_operand_reg[31];
    wire       gt = $signed(dest_operand_reg) > $signed(source_operand_reg);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_step;
        c == 4'hD;
    endsequence
    a_clear_flag: assert property (c == 4'h1 |=> !flag_t) else $error("clr");
    a_pc_step: assert property (c != 4'h0 |=> pc == $past(pc) + 32'h2) else $error("pc");
    a_eq_flag: assert property (c == 4'h2 |=> flag_t == $past(eq)) else $error("eq");
    a_hi_flag: assert property (c == 4'h5 |=> flag_t == $past(hi)) else $error("hi");
    a_gt_flag: assert property (c == 4'h4 |=> flag_t == $past(gt)) else $error("gt");
    a_no_write: assert property (c != 4'h0 && c != 4'hD |=> !wr_en) else $error("wr");
    a_uinit_clear: assert property (c == 4'hC
        |=> !(flag_t | dividend_sign | divisor_sign)) else $error("uinit");
    a_sinit_sign: assert property (c == 4'hB |=> divisor_sign == $past(ms)
        && dividend_sign == $past(ds) && flag_t == (dividend_sign ^ divisor_sign))
        else $error("sinit");
    a_step_flag: assert property (s_step
        |=> wr_en && flag_t == (dividend_sign == divisor_sign)) else $error("step");
endmodule
bind cda_alu cda_alu_asserts u_chk (.clk(clk), .rstn(rstn), .op_valid(op_valid),
    .op_code(op_code), .dest_operand_reg(dest_operand_reg),
    .source_operand_reg(source_operand_reg), .flag_t(flag_t), .dividend_sign(dividend_sign),
    .divisor_sign(divisor_sign), .pc(pc), .wr_en(wr_en));

// *** tb/cda_regfile_model.sv ***
// Register file model holding the dividend register
module cda_regfile_model
(
    input wire        clk,
    input wire        ld,
    input wire [31:0] ld_val,
    input wire        wr_en,
    input wire [31:0] wr_data,
    output reg [31:0] dvd
);
    timeunit 1ns;
    timeprecision 1ns;
    // Only the slice's write-back touches the dividend mid-sequence
    always @(posedge clk)
        if (ld) dvd <= ld_val;
        else if (wr_en) dvd <= wr_data;
endmodule

// *** tb/test_compare_and_divide_step_alu.sv ***
// Self-checking bench for the compare and divide step slice
module test_compare_and_divide_step_alu;
    timeunit 1ns;
    timeprecision 1ns;
    reg         clk = 0, rstn = 0, v = 0, rf = 0, ld = 0;
    reg  [3:0]  oc = '0;
    reg  [31:0] dn = '0, sm = '0, r0 = '0;
    reg  [7:0]  im = '0;
    wire [31:0] dvd, wd, pc;
    wire        t, q, m, we;
    integer     err_total = 0, total_checks = 0, nops = 0, cyc = 0, i;
    always #12.5 clk = ~clk;
    cda_alu DUT (.clk(clk), .rstn(rstn), .op_valid(v), .op_code(oc),
        .dest_operand_reg(rf ? dvd : dn), .source_operand_reg(sm), .reg_zero(r0),
        .imm(im), .flag_t(t), .dividend_sign(q), .divisor_sign(m), .pc(pc),
        .wr_en(we), .wr_data(wd));
    cda_regfile_model u_rf (.clk(clk), .ld(ld), .ld_val(dn), .wr_en(we), .wr_data(wd),
        .dvd(dvd));
    task chk(input string nm, input [31:0] e, g);
        total_checks++;
        if (g !== e)
        begin
            err_total++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask
    task op(input [3:0] c, input [31:0] n, s);
        @(posedge clk);
        #1 v = 1;
        oc = c;
        dn = n;
        sm = s;
        @(posedge clk);
        #1 v = 0;
        nops++;
    endtask
    task cmp(input [3:0] c, input [31:0] n, s, input e);
        op(c, n, s);
        chk("flag", e, t);
    endtask
    task t_flags;
        cmp(4'h2, 32'h1234_5678, 32'h1234_5678, 1);
        cmp(4'h1, 32'h0, 32'h0, 0);
        cmp(4'h6, 32'h8000_0000, 32'h7FFF_FFFF, 1);
        cmp(4'h3, 32'h8000_0000, 32'h7FFF_FFFF, 0);
        cmp(4'h5, 32'h8000_0000, 32'h7FFF_FFFF, 1);
        cmp(4'h4, 32'h7FFF_FFFF, 32'h7FFF_FFFF, 0);
        cmp(4'h8, 32'h0, 32'h0, 1);
        cmp(4'h7, 32'h0, 32'h0, 0);
        cmp(4'h9, 32'h4142_4344, 32'h5859_435A, 1);
        cmp(4'h9, 32'h0102_0304, 32'h0506_0708, 0);
        r0 = 32'hFFFF_FF80;
        im = 8'h80;
        cmp(4'hA, 32'h0, 32'h0, 1);
        r0 = 32'h0000_0080;
        cmp(4'hA, 32'h0, 32'h0, 0);
        cmp(4'hB, 32'h8000_0000, 32'h1, 1);
        chk("qm", 32'h2, {q, m});
        cmp(4'hE, 32'h0, 32'h0, 1);
    endtask
    task t_div;
        dn = 32'h0000_0064;
        ld = 1;
        @(posedge clk);
        #1 ld = 0;
        rf = 1;
        cmp(4'hC, 32'h0, 32'h0, 0);
        for (i = 0; i < 16; i++)
            op(4'hD, 32'h0, 32'h0007_0000);
        @(posedge clk);
        #1 chk("quot", 32'h0000_0064 / 32'h7, {16'h0, dvd[14:0], t});
    endtask
    task conclude;
        if (err_total == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk)
        if (++cyc == 500)
        begin
            err_total++;
            conclude;
        end
    initial
    begin
        repeat (3) @(posedge clk);
        #1 rstn = 1;
        t_flags;
        t_div;
        chk("pc", nops * 2, pc);
        @(posedge clk);
        #1 rstn = 0;
        @(posedge clk);
        #1 rstn = 1;
        chk("rst_pc", 32'h0, pc);
        chk("rst_st", 32'h0, {t, q, m, we});
        conclude;
    end
endmodule
